// ### logic/serial_sram_command_engine.sv
// Purpose: Slave command engine of a 64K x 8 serial SRAM.
// Assumes: sck is the link clock; clk only carries status to the system.
// Notes: Frame state clears while chip select is high.
`timescale 1ns/1ns
`include "sram_engine_cfg.svh"

module serial_sram_command_engine
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int PAGE_BITS = `PAGE_BITS
)
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic io_lane_0_in,
  output logic io_lane_0_out,
  output logic io_lane_0_oe,
  input wire logic io_lane_1_in,
  output logic io_lane_1_out,
  output logic io_lane_1_oe,
  input wire logic io_lane_2_in,
  output logic io_lane_2_out,
  output logic io_lane_2_oe,
  input wire logic io_lane_3_in,
  output logic io_lane_3_out,
  output logic io_lane_3_oe,
  // Status in the system clock domain
  output logic selected_ff,
  output logic [1:0] mode_status_ff,
  output logic [2:0] lane_status_ff
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  function automatic logic [3:0] step_of(input logic [2:0] lanes);
    case (lanes)
      3'h2: step_of = `STEP_DUAL;
      3'h4: step_of = `STEP_QUAD;
      default: step_of = `STEP_SINGLE;
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input logic [2:0] lanes);
    case (lanes)
      3'h2: oe_of = `OE_DUAL;
      3'h4: oe_of = `OE_QUAD;
      default: oe_of = `OE_SINGLE;
    endcase
  endfunction

  // Shifts the lane bits in below the byte, highest lane first.
  function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                          input logic [3:0] pins,
                                          input logic [2:0] lanes);
    case (lanes)
      3'h2: shift_in = {sh[5:0], pins[1:0]};
      3'h4: shift_in = {sh[3:0], pins};
      default: shift_in = {sh[6:0], pins[0]};
    endcase
  endfunction

  // Places the top bits of a byte on the lanes that drive out.
  function automatic logic [3:0] top_bits(input logic [7:0] b,
                                          input logic [2:0] lanes);
    case (lanes)
      3'h2: top_bits = {2'h0, b[7:6]};
      3'h4: top_bits = b[7:4];
      default: top_bits = {2'h0, b[7], 1'b0};
    endcase
  endfunction

  // Next array address under the selected addressing mode.
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] mode);
    logic [ADDR_W-1:0] inc;
    inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    if (mode == `MODE_PAGE)
      next_addr = {a[ADDR_W-1:PAGE_BITS], inc[PAGE_BITS-1:0]};
    else
      next_addr = inc;
  endfunction

  // --------------------------------------------------------------------
  // Link domain storage and declarations
  // --------------------------------------------------------------------
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  sram_engine_pkg::seq_state_type state_ff;
  sram_engine_pkg::seq_state_type nxt_state;
  sram_engine_pkg::lane_mode_type lane_ff;
  logic [1:0] mode_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [ADDR_W-1:0] addr_ff;
  logic addr_hi_ff;
  logic is_read_ff;
  logic hold_ff;
  logic cfg_tog_ff;
  logic [7:0] out_sh_ff;
  logic [3:0] out_bits_ff;
  logic [3:0] oe_ff;
  logic frame_rst;
  logic [3:0] pins;
  logic [3:0] step;
  logic byte_done;
  logic wr_en;

  // Frame state clears whenever chip select is high.
  assign frame_rst = rst | cs_n;
  assign pins = {io_lane_3_in, io_lane_2_in, io_lane_1_in, io_lane_0_in};
  assign step = step_of(lane_ff);
  assign nxt_sh = shift_in(sh_ff, pins, lane_ff);
  assign byte_done = !hold_ff && ((cnt_ff + step) == `BYTE_BITS);
  assign wr_en = byte_done && (state_ff == sram_engine_pkg::st_write);

  // --------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    if (byte_done)
    begin
      case (state_ff)
        sram_engine_pkg::st_cmd:
        begin
          case (nxt_sh)
            `CMD_READ, `CMD_WRITE: nxt_state = sram_engine_pkg::st_addr;
            `CMD_READ_MODE: nxt_state = sram_engine_pkg::st_mode_rd;
            `CMD_WRITE_MODE: nxt_state = sram_engine_pkg::st_mode_wr;
            default: nxt_state = sram_engine_pkg::st_ignore;
          endcase
        end
        sram_engine_pkg::st_addr:
        begin
          if (addr_hi_ff)
            nxt_state = is_read_ff ? sram_engine_pkg::st_read
                                   : sram_engine_pkg::st_write;
        end
        sram_engine_pkg::st_write, sram_engine_pkg::st_read:
        begin
          if (mode_ff == `MODE_BYTE)
            nxt_state = sram_engine_pkg::st_ignore;
        end
        sram_engine_pkg::st_mode_wr:
          nxt_state = sram_engine_pkg::st_ignore;
        default:
          nxt_state = state_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Rising edge: sequence state and shift counting
  // --------------------------------------------------------------------
  always_ff @(posedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state_ff <= sram_engine_pkg::st_cmd;
      cnt_ff <= `CNT_ZERO;
      sh_ff <= 8'h00;
    end
    else if (!hold_ff)
    begin
      state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      cnt_ff <= byte_done ? `CNT_ZERO : 4'(cnt_ff + step);
    end
  end

  // --------------------------------------------------------------------
  // Rising edge: address pointer
  // --------------------------------------------------------------------
  always_ff @(posedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      addr_ff <= {ADDR_W{1'b0}};
      addr_hi_ff <= 1'b0;
      is_read_ff <= 1'b0;
    end
    else if (byte_done)
    begin
      case (state_ff)
        sram_engine_pkg::st_cmd:
          is_read_ff <= (nxt_sh == `CMD_READ);
        sram_engine_pkg::st_addr:
        begin
          addr_hi_ff <= 1'b1;
          addr_ff <= {addr_ff[ADDR_W-9:0], nxt_sh};
        end
        sram_engine_pkg::st_write, sram_engine_pkg::st_read:
          addr_ff <= next_addr(addr_ff, mode_ff);
        default:
          addr_ff <= addr_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Rising edge: array write
  // --------------------------------------------------------------------
  always_ff @(posedge sck)
  begin
    if (wr_en)
      mem[addr_ff] <= nxt_sh;
  end

  // --------------------------------------------------------------------
  // Rising edge: mode register and lane width
  // --------------------------------------------------------------------
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
      mode_ff <= `MODE_RESET;
    else if (!cs_n && byte_done && state_ff == sram_engine_pkg::st_mode_wr)
      mode_ff <= nxt_sh[`MODE_MSB:`MODE_LSB];
  end

  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
      lane_ff <= sram_engine_pkg::single_lane_mode;
    else if (!cs_n && byte_done && state_ff == sram_engine_pkg::st_cmd)
    begin
      case (nxt_sh)
        `CMD_ENTER_DUAL: lane_ff <= sram_engine_pkg::dual_lane_mode;
        `CMD_ENTER_QUAD: lane_ff <= sram_engine_pkg::quad_lane_mode;
        `CMD_EXIT_MULTI: lane_ff <= sram_engine_pkg::single_lane_mode;
        default: lane_ff <= lane_ff;
      endcase
    end
  end

  // Flips on every configuration change for the system side to follow.
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
      cfg_tog_ff <= 1'b0;
    else if (!cs_n && byte_done &&
             (state_ff == sram_engine_pkg::st_mode_wr ||
              (state_ff == sram_engine_pkg::st_cmd &&
               (nxt_sh == `CMD_ENTER_DUAL || nxt_sh == `CMD_ENTER_QUAD ||
                nxt_sh == `CMD_EXIT_MULTI))))
      cfg_tog_ff <= ~cfg_tog_ff;
  end

  // --------------------------------------------------------------------
  // Falling edge: hold sampling and output shifting
  // --------------------------------------------------------------------
  always_ff @(negedge sck or posedge frame_rst)
  begin
    if (frame_rst)
      hold_ff <= 1'b0;
    else
      hold_ff <= (lane_ff != sram_engine_pkg::quad_lane_mode) &&
                 !io_lane_3_in;
  end

  always_ff @(negedge sck or posedge frame_rst)
  begin
    logic [7:0] src;
    src = 8'h00;
    if (frame_rst)
    begin
      out_sh_ff <= 8'h00;
      out_bits_ff <= 4'h0;
      oe_ff <= 4'h0;
    end
    else if ((state_ff == sram_engine_pkg::st_read ||
              state_ff == sram_engine_pkg::st_mode_rd) &&
             !((lane_ff != sram_engine_pkg::quad_lane_mode) &&
               !io_lane_3_in))
    begin
      if (cnt_ff != `CNT_ZERO)
        src = out_sh_ff;
      else if (state_ff == sram_engine_pkg::st_read)
        src = mem[addr_ff];
      else
        src = {mode_ff, `MODE_LOW_BITS};
      out_bits_ff <= top_bits(src, lane_ff);
      out_sh_ff <= 8'(src << step);
      oe_ff <= oe_of(lane_ff);
    end
    else
      oe_ff <= 4'h0;
  end

  assign io_lane_0_out = out_bits_ff[0];
  assign io_lane_1_out = out_bits_ff[1];
  assign io_lane_2_out = out_bits_ff[2];
  assign io_lane_3_out = out_bits_ff[3];
  assign io_lane_0_oe = oe_ff[0];
  assign io_lane_1_oe = oe_ff[1];
  assign io_lane_2_oe = oe_ff[2];
  assign io_lane_3_oe = oe_ff[3];

  // --------------------------------------------------------------------
  // System domain: status crossing
  // --------------------------------------------------------------------
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic tog_meta_ff;
  logic tog_sync_ff;
  logic tog_seen_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      selected_ff <= 1'b0;
    end
    else
    begin
      cs_meta_ff <= cs_n;
      cs_sync_ff <= cs_meta_ff;
      selected_ff <= !cs_sync_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tog_meta_ff <= 1'b0;
      tog_sync_ff <= 1'b0;
      tog_seen_ff <= 1'b0;
    end
    else
    begin
      tog_meta_ff <= cfg_tog_ff;
      tog_sync_ff <= tog_meta_ff;
      tog_seen_ff <= tog_sync_ff;
    end
  end

  // The words are stable by the time the synchronised toggle arrives.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_status_ff <= `MODE_RESET;
      lane_status_ff <= sram_engine_pkg::single_lane_mode;
    end
    else if (tog_sync_ff != tog_seen_ff)
    begin
      mode_status_ff <= mode_ff;
      lane_status_ff <= lane_ff;
    end
  end

endmodule

// ### logic/sram_engine_cfg.svh
// Purpose: Constants of the serial SRAM command engine.
// Assumes: Included by its bare name from the engine module.
// Notes: Definitions only.
`ifndef SRAM_ENGINE_CFG_SVH
`define SRAM_ENGINE_CFG_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define CMD_READ 8'h03
`define CMD_WRITE 8'h02
`define CMD_ENTER_DUAL 8'h3b
`define CMD_ENTER_QUAD 8'h38
`define CMD_EXIT_MULTI 8'h ff
`define CMD_READ_MODE 8'h05
`define CMD_WRITE_MODE 8'h01

// ----------------------------------------------------------------------
// Mode field, bits 7 and 6 of the operating mode register
// ----------------------------------------------------------------------
`define MODE_MSB 7
`define MODE_LSB 6
`define MODE_BYTE 2'h0
`define MODE_PAGE 2'h2
`define MODE_SEQ 2'h1
`define MODE_RESET 2'h1
`define MODE_LOW_BITS 6'h00

// ----------------------------------------------------------------------
// Array geometry and shift counting
// ----------------------------------------------------------------------
`define ADDR_W 16
`define PAGE_BITS 5
`define BYTE_BITS 4'h8
`define CNT_ZERO 4'h0
`define STEP_SINGLE 4'h1
`define STEP_DUAL 4'h2
`define STEP_QUAD 4'h4
`define OE_SINGLE 4'h2
`define OE_DUAL 4'h3
`define OE_QUAD 4'hf

`endif

// ### logic/sram_engine_pkg.sv
// Purpose: Types shared by the serial SRAM command engine.
// Assumes: Nothing is imported; users write the package name.
// Notes: State and lane codes are one-hot.
package sram_engine_pkg;

  // --------------------------------------------------------------------
  // Sequence states
  // --------------------------------------------------------------------
  typedef enum logic [6:0]
  {
    st_cmd     = 7'h01,
    st_addr    = 7'h02,
    st_write   = 7'h04,
    st_read    = 7'h08,
    st_mode_wr = 7'h10,
    st_mode_rd = 7'h20,
    st_ignore  = 7'h40
  } seq_state_type;

  // --------------------------------------------------------------------
  // Bus width on the data lanes
  // --------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    single_lane_mode = 3'h1,
    dual_lane_mode   = 3'h2,
    quad_lane_mode   = 3'h4
  } lane_mode_type;

endpackage

// ### verif/spi_host_model.sv
// Purpose: Host controller driving the serial link of the SRAM engine.
// Assumes: Link clock idles low and runs only inside frames.
// Notes: Lane levels resolve host and device drive.
`timescale 1ns/1ns
module spi_host_model
(
  // Link pins
  output logic sck,
  output logic cs_n,
  output logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  logic [3:0] hv;
  logic oe_seen;
  // A lane shows the device while it drives, else the host level.
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & hv);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    hv = 4'h8;
    oe_seen = 1'b0;
  end
  task automatic start();
    #24 cs_n = 1'b0;
    oe_seen = 1'b0;
    #24;
  endtask
  task automatic stop();
    #24 cs_n = 1'b1;
    hv = 4'h8;
    #48;
  endtask
  // Moves one byte at w bits per clock; hold stays high below quad.
  task automatic xfer(input logic [7:0] tx, input int w,
    output logic [7:0] rx);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    rx = 8'h00;
    for (int i = 8 - w; i >= 0; i -= w)
    begin
      hv = (4'(tx >> i) & m) | (w < 4 ? 4'h8 : 4'h0);
      #24 sck = 1'b1;
      rx = 8'((rx << w) | ((w == 1 ? {3'h0, lane_in[1]} : lane_in) & m));
      oe_seen = oe_seen | (|lane_oe);
      #24 sck = 1'b0;
    end
  endtask
endmodule

// ### verif/sram_engine_checker.sv
// Purpose: Assertions on the serial SRAM engine ports.
// Assumes: Bit-level checks apply to single-lane frames.
// Notes: Bound from the bench top file.
`timescale 1ns/1ns
`include "sram_engine_cfg.svh"
module sram_engine_checker
(
  // System side
  input logic clk,
  input logic rst,
  input logic selected_ff,
  input logic [1:0] mode_status_ff,
  input logic [2:0] lane_status_ff,
  // Link side
  input logic sck,
  input logic cs_n,
  input logic io_lane_0_in,
  input logic io_lane_0_oe,
  input logic io_lane_1_out,
  input logic io_lane_1_oe,
  input logic io_lane_2_oe,
  input logic io_lane_3_oe
);
  logic [7:0] cnt_ff;
  logic [7:0] cmd_ff;
  logic [7:0] mbyte;
  logic one;
  logic any_oe;
  assign mbyte = {mode_status_ff, 6'h00};
  assign one = lane_status_ff == 3'h1;
  assign any_oe = io_lane_0_oe | io_lane_1_oe | io_lane_2_oe | io_lane_3_oe;

  // Counts rising link edges of a frame and keeps its command byte.
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
      cnt_ff <= 8'h00;
    else if (cnt_ff != 8'hff)
      cnt_ff <= cnt_ff + 8'h01;
  end
  always_ff @(posedge sck)
  begin
    if (cnt_ff < 8'h08)
      cmd_ff <= {cmd_ff[6:0], io_lane_0_in};
  end

  a_desel_release: assert property (@(posedge clk) disable iff (rst)
    cs_n |-> !any_oe) else $error("lanes driven while deselected");
  a_select_follow: assert property (@(posedge clk) disable iff (rst)
    $fell(cs_n) |-> ##[1:3] selected_ff) else $error("select not seen");
  a_reset_state: assert property (@(posedge clk) rst |=>
    mbyte == 8'h40 && one && !selected_ff) else $error("bad reset state");
  a_lane_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot(lane_status_ff)) else $error("lane status not one-hot");
  a_single_lanes: assert property (@(posedge clk) disable iff (rst)
    one && $stable(lane_status_ff) |-> !(io_lane_0_oe || io_lane_2_oe
    || io_lane_3_oe)) else $error("extra lane driven");
  a_read_wait: assert property (@(posedge sck) disable iff (rst || cs_n)
    one && cmd_ff == `CMD_READ && cnt_ff inside {[8:23]} |-> !io_lane_1_oe)
    else $error("read data too early");
  a_read_start: assert property (@(posedge sck) disable iff (rst || cs_n)
    one && cmd_ff == `CMD_READ && cnt_ff == 8'd24 |-> io_lane_1_oe)
    else $error("read data missing");
  a_mode_bits: assert property (@(posedge sck) disable iff (rst || cs_n)
    one && cmd_ff == `CMD_READ_MODE && cnt_ff inside {[8:254]} |->
    io_lane_1_out == mbyte[3'd7 - cnt_ff[2:0]]) else $error("mode bit");
  a_unknown_quiet: assert property (@(posedge sck) disable iff (rst || cs_n)
    one && cnt_ff >= 8'd8 && !(cmd_ff inside {`CMD_READ, `CMD_WRITE,
    `CMD_ENTER_DUAL, `CMD_ENTER_QUAD, `CMD_EXIT_MULTI, `CMD_READ_MODE,
    `CMD_WRITE_MODE}) |-> !io_lane_1_oe) else $error("unknown answered");
  a_byte_single: assert property (@(posedge sck) disable iff (rst || cs_n)
    one && mode_status_ff == 2'h0 && cmd_ff == `CMD_READ &&
    cnt_ff inside {[33:254]} |-> !io_lane_1_oe) else $error("extra byte");

  c_read: cover property (@(posedge sck) cnt_ff == 8'd24 && io_lane_1_oe);
  c_quad: cover property (@(posedge clk) lane_status_ff == 3'h4);
  c_page: cover property (@(posedge clk) mode_status_ff == 2'h2);
endmodule

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the serial SRAM engine.
// Assumes: Status settles within six system clocks.
// Notes: Memory is checked by writing and reading back.
`timescale 1ns/1ns
`include "sram_engine_cfg.svh"
module tb_top;
  logic clk;
  logic rst;
  logic sck;
  logic cs_n;
  logic [3:0] lin;
  logic [3:0] lout;
  logic [3:0] loe;
  logic sel;
  logic [1:0] mst;
  logic [2:0] lst;
  logic [7:0] rb [0:3];
  logic [7:0] rx;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  serial_sram_command_engine u_serial_sram_command_engine
  (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n),
    .io_lane_0_in(lin[0]), .io_lane_0_out(lout[0]), .io_lane_0_oe(loe[0]),
    .io_lane_1_in(lin[1]), .io_lane_1_out(lout[1]), .io_lane_1_oe(loe[1]),
    .io_lane_2_in(lin[2]), .io_lane_2_out(lout[2]), .io_lane_2_oe(loe[2]),
    .io_lane_3_in(lin[3]), .io_lane_3_out(lout[3]), .io_lane_3_oe(loe[3]),
    .selected_ff(sel), .mode_status_ff(mst), .lane_status_ff(lst)
  );
  spi_host_model u_spi_host_model
  (
    .sck(sck), .cs_n(cs_n), .lane_in(lin), .lane_out(lout), .lane_oe(loe)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      $display("[ERR] %0t run too long", $time);
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input int w);
    u_spi_host_model.start();
    u_spi_host_model.xfer(c, w, rx);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] p,
    input int n, input int w);
    cmd(`CMD_WRITE, w);
    u_spi_host_model.xfer(a[15:8], w, rx);
    u_spi_host_model.xfer(a[7:0], w, rx);
    for (int i = 0; i < n; i++)
      u_spi_host_model.xfer(p + 8'(i), w, rx);
    u_spi_host_model.stop();
  endtask
  task automatic rdw(input logic [15:0] a, input int n, input int w);
    cmd(`CMD_READ, w);
    u_spi_host_model.xfer(a[15:8], w, rx);
    u_spi_host_model.xfer(a[7:0], w, rx);
    for (int i = 0; i < n; i++)
      u_spi_host_model.xfer(8'h00, w, rb[i]);
    u_spi_host_model.stop();
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    rdw(a, n, 1);
  endtask
  task automatic setm(input logic [7:0] m);
    cmd(`CMD_WRITE_MODE, 1);
    u_spi_host_model.xfer(m, 1, rx);
    u_spi_host_model.stop();
    repeat (6) @(posedge clk);
    chk({6'h00, mst}, {6'h00, m[7:6]});
  endtask
  task automatic lanes(input logic [7:0] c, input int w, input logic [2:0] e);
    cmd(c, w);
    u_spi_host_model.stop();
    repeat (6) @(posedge clk);
    chk({5'h00, lst}, {5'h00, e});
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chk({sel, loe, 1'b0, mst}, 8'h01);
    chk({5'h00, lst}, 8'h01);
    cmd(`CMD_READ_MODE, 1);
    u_spi_host_model.xfer(8'h00, 1, rb[0]);
    u_spi_host_model.xfer(8'h00, 1, rb[1]);
    u_spi_host_model.stop();
    chk(rb[0], 8'h40);
    chk(rb[1], 8'h40);
    wr(16'hffff, 8'ha0, 3, 1);
    rd(16'hffff, 3);
    for (int i = 0; i < 3; i++)
      chk(rb[i], 8'ha0 + 8'(i));
    wr(16'h001e, 8'h10, 4, 1);
    rd(16'h001e, 4);
    for (int i = 0; i < 4; i++)
      chk(rb[i], 8'h10 + 8'(i));
    wr(16'h0100, 8'hc0, 2, 1);
    setm(8'h80);
    wr(16'h003e, 8'h50, 3, 1);
    rd(16'h003f, 2);
    chk(rb[0], 8'h51);
    chk(rb[1], 8'h52);
    wr(16'h0040, 8'h00, 33, 1);
    rd(16'h0040, 2);
    chk(rb[0], 8'h20);
    chk(rb[1], 8'h01);
    setm(8'h00);
    wr(16'h0100, 8'h77, 2, 1);
    rd(16'h0100, 2);
    chk(rb[0], 8'h77);
    setm(8'h40);
    rd(16'h0100, 2);
    chk(rb[1], 8'hc1);
    cmd(8'h77, 1);
    u_spi_host_model.xfer(8'h00, 1, rx);
    u_spi_host_model.xfer(8'h00, 1, rx);
    u_spi_host_model.stop();
    chk({7'h00, u_spi_host_model.oe_seen}, 8'h00);
    for (int w = 2; w <= 4; w += 2)
    begin
      lanes(w == 2 ? `CMD_ENTER_DUAL : `CMD_ENTER_QUAD, 1, 3'(w));
      wr(16'h0200 + 16'(w), 8'he0 + 8'(w), 1, w);
      rdw(16'h0200 + 16'(w), 1, w);
      chk(rb[0], 8'he0 + 8'(w));
      lanes(`CMD_EXIT_MULTI, w, 3'h1);
      rd(16'h0200 + 16'(w), 1);
      chk(rb[0], 8'he0 + 8'(w));
    end
    chk({4'h0, loe}, 8'h00);
    print_verdict();
  end
endmodule

bind serial_sram_command_engine sram_engine_checker u_sram_engine_checker
(
  .clk(clk),
  .rst(rst),
  .selected_ff(selected_ff),
  .mode_status_ff(mode_status_ff),
  .lane_status_ff(lane_status_ff),
  .sck(sck),
  .cs_n(cs_n),
  .io_lane_0_in(io_lane_0_in),
  .io_lane_0_oe(io_lane_0_oe),
  .io_lane_1_out(io_lane_1_out),
  .io_lane_1_oe(io_lane_1_oe),
  .io_lane_2_oe(io_lane_2_oe),
  .io_lane_3_oe(io_lane_3_oe)
);
